// File: verilog/ddps_regs.svh
// Register offsets, field positions, reset values and constants for the
// dual data pointer select block. Definitions only; include by bare name.
`ifndef DDPS_REGS_SVH
`define DDPS_REGS_SVH

// Word indices; byte address is four times the index
`define DDPS_AUX_IDX 10'h0A2
`define DDPS_PTR_IDX 10'h0A3
`define DDPS_CMD_IDX 10'h0A4
`define DDPS_BOTH_IDX 10'h0A5

// Fields of the auxiliary pointer control register
`define DDPS_CHOICE_BIT 0
`define DDPS_FLAG_BIT 3
`define DDPS_AUX_RST 8'h00
`define DDPS_RSVD_READ 8'h00

// Fields of the pointer command register
`define DDPS_CMD_TOGGLE_BIT 0
`define DDPS_CMD_INC_BIT 1

// Pointer reset value and documented width
`define DDPS_PTR_RST 16'h0000
`define DDPS_PTR_W 16

`endif

// File: verilog/ddps_pkg.sv
// Types shared by the dual data pointer select block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ddps_pkg;

  // Operation requested by the core execution logic in one cycle
  typedef enum logic [2:0] {
    DDPS_OP_NOP = 3'b000,
    DDPS_OP_LOAD = 3'b001,
    DDPS_OP_INC = 3'b010,
    DDPS_OP_AUX_INC = 3'b011,
    DDPS_OP_AUX_WR = 3'b100
  } ddps_op_e;

  // Data phase of the bus slave
  typedef enum logic [1:0] {
    DDPS_DP_IDLE = 2'b00,
    DDPS_DP_READ = 2'b01,
    DDPS_DP_WRITE = 2'b10
  } ddps_dp_e;

endpackage
`default_nettype wire

// File: verilog/ddps_ptr_if.sv
// Carrier between the control logic and the pointer bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ddps_ptr_if #(
  parameter int PTR_W = 16
);
  logic sel;
  logic load;
  logic inc;
  logic [PTR_W-1:0] load_val;
  logic [PTR_W-1:0] ptr0;
  logic [PTR_W-1:0] ptr1;
  logic [PTR_W-1:0] ptr0_d;
  logic [PTR_W-1:0] ptr1_d;

  modport bank (input sel, load, inc, load_val, output ptr0, ptr1, ptr0_d, ptr1_d);
  modport ctrl (output sel, load, inc, load_val, input ptr0, ptr1, ptr0_d, ptr1_d);
endinterface
`default_nettype wire

// File: verilog/ddps_ptr_bank.sv
// Two pointer registers; load and increment act on the selected one only.
// Assumes the controller never asserts load and inc in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ddps_regs.svh"
module ddps_ptr_bank #(
  parameter int PTR_W = `DDPS_PTR_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  ddps_ptr_if.bank pif
);

  logic [PTR_W-1:0] ptr0_q;
  logic [PTR_W-1:0] ptr1_q;
  logic [PTR_W-1:0] ptr0_d;
  logic [PTR_W-1:0] ptr1_d;
  logic [PTR_W-1:0] cur;
  logic [PTR_W-1:0] nxt;

  // Next value for the selected pointer; the other one holds
  always_comb begin
    cur = pif.sel ? ptr1_q : ptr0_q;
    nxt = cur;
    if (pif.load) begin
      nxt = pif.load_val;
    end else if (pif.inc) begin
      nxt = cur + PTR_W'(1); // Wraps at the top of memory
    end
    ptr0_d = pif.sel ? ptr0_q : nxt;
    ptr1_d = pif.sel ? nxt : ptr1_q;
  end

  // Two independent registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr0_q <= PTR_W'(`DDPS_PTR_RST);
      ptr1_q <= PTR_W'(`DDPS_PTR_RST);
    end else begin
      ptr0_q <= ptr0_d;
      ptr1_q <= ptr1_d;
    end
  end

  assign pif.ptr0 = ptr0_q;
  assign pif.ptr1 = ptr1_q;
  assign pif.ptr0_d = ptr0_d;
  assign pif.ptr1_d = ptr1_d;

endmodule
`default_nettype wire

// File: verilog/ddps_top.sv
// Dual data pointer select block: two external address pointers, the
// auxiliary pointer control register, an AHB-Lite slave and a core port.
// Assumes one 20 MHz clock, synchronous active-high reset, one bus master.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ddps_regs.svh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Two independent pointers address external data
// - Pointer choice sits in control bit 0
// - Choice 0 picks pointer zero, 1 pointer one
// - User flag bit is freely read and written
// - Build option removes the user flag bit
// - Unimplemented bits read back a fixed constant
// - Future reserved features reset 0, active 1
// - Incrementing the control register toggles the choice
module ddps_top #(
  parameter int PTR_W = `DDPS_PTR_W,
  parameter bit HAS_USER_FLAG = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire ddps_pkg::ddps_op_e core_op,
  input wire logic [15:0] core_data,
  output logic [PTR_W-1:0] ext_addr,
  output logic pointer_choice
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (PTR_W < 1 || PTR_W > 16) begin : g_bad_width
    $error("ddps_top: PTR_W must lie between 1 and 16");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word index match; upper address bits must be zero
  function automatic logic hit(input logic [31:0] a, input logic [9:0] idx);
    hit = (a[31:12] == 20'h00000) && (a[11:2] == idx);
  endfunction

  // Mask of implemented bits in the control register
  function automatic logic [7:0] impl_mask(input bit flag_on);
    logic [7:0] m;
    m = 8'h00;
    m[`DDPS_CHOICE_BIT] = 1'b1;
    m[`DDPS_FLAG_BIT] = flag_on;
    impl_mask = m;
  endfunction

  localparam logic [7:0] AUX_MASK = impl_mask(HAS_USER_FLAG);

  ////////////////////////////////////////////////////////////////////////
  // Pointer bank
  ddps_ptr_if #(.PTR_W(PTR_W)) pif ();

  ddps_ptr_bank #(
    .PTR_W(PTR_W)
  ) ddps_ptr_bank_i (
    .ref_clk(ref_clk),
    .rst(rst),
    .pif(pif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus address and data phase state
  ddps_pkg::ddps_dp_e dp_q;
  ddps_pkg::ddps_dp_e dp_d;
  logic [9:0] idx_q;
  logic [9:0] idx_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic take;
  logic map_ok;
  logic wr_go;
  logic core_busy;

  // Core activity blocks a bus write so the two never collide
  assign core_busy = (core_op != ddps_pkg::DDPS_OP_NOP);
  assign hreadyout = !((dp_q == ddps_pkg::DDPS_DP_WRITE) && core_busy);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign wr_go = (dp_q == ddps_pkg::DDPS_DP_WRITE) && !core_busy;
  assign take = hsel && hready && htrans[1];

  // Auxiliary control register state
  logic [7:0] aux_q;
  logic [7:0] aux_d;
  logic [7:0] aux_rd;

  // Read view: implemented bits live, the rest a fixed constant
  assign aux_rd = (aux_q & AUX_MASK) | (`DDPS_RSVD_READ & ~AUX_MASK);

  // Decode of an address phase and the read value it returns
  always_comb begin
    dp_d = dp_q;
    idx_d = idx_q;
    rdata_d = rdata_q;
    map_ok = hit(haddr, `DDPS_AUX_IDX) || hit(haddr, `DDPS_PTR_IDX) ||
             hit(haddr, `DDPS_CMD_IDX) || hit(haddr, `DDPS_BOTH_IDX);
    if (hreadyout) begin
      dp_d = ddps_pkg::DDPS_DP_IDLE;
      if (take) begin
        idx_d = haddr[11:2];
        dp_d = hwrite ? ddps_pkg::DDPS_DP_WRITE : ddps_pkg::DDPS_DP_READ;
        rdata_d = 32'h00000000; // Unmapped and write-only read as zero
        if (!hwrite && map_ok) begin
          if (hit(haddr, `DDPS_AUX_IDX)) begin
            rdata_d = {24'h000000, aux_rd};
          end else if (hit(haddr, `DDPS_PTR_IDX)) begin
            rdata_d = 32'(ext_addr);
          end else if (hit(haddr, `DDPS_BOTH_IDX)) begin
            rdata_d = {16'(pif.ptr1), 16'(pif.ptr0)};
          end
        end
      end
    end
  end

  // Bus phase registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dp_q <= ddps_pkg::DDPS_DP_IDLE;
      idx_q <= 10'h000;
      rdata_q <= 32'h00000000;
    end else begin
      dp_q <= dp_d;
      idx_q <= idx_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register and pointer requests
  logic bus_aux_wr;
  logic bus_ptr_wr;
  logic bus_cmd_wr;

  assign bus_aux_wr = wr_go && (idx_q == `DDPS_AUX_IDX);
  assign bus_ptr_wr = wr_go && (idx_q == `DDPS_PTR_IDX);
  assign bus_cmd_wr = wr_go && (idx_q == `DDPS_CMD_IDX);

  // Next control value: writes keep only implemented bits, so a stray
  // reserved one never lands; an increment adds one and drops the carry
  always_comb begin
    aux_d = aux_q;
    case (core_op)
      ddps_pkg::DDPS_OP_AUX_WR: begin
        aux_d = core_data[7:0] & AUX_MASK;
      end
      ddps_pkg::DDPS_OP_AUX_INC: begin
        aux_d = (aux_q + 8'h01) & AUX_MASK;
        aux_d[`DDPS_FLAG_BIT] = aux_q[`DDPS_FLAG_BIT] & AUX_MASK[`DDPS_FLAG_BIT];
      end
      default: begin
        if (bus_aux_wr) begin
          aux_d = hwdata[7:0] & AUX_MASK;
        end else if (bus_cmd_wr && hwdata[`DDPS_CMD_TOGGLE_BIT]) begin
          aux_d[`DDPS_CHOICE_BIT] = !aux_q[`DDPS_CHOICE_BIT];
        end
      end
    endcase
  end

  // Control register; reserved positions stay 0 from reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aux_q <= `DDPS_AUX_RST;
    end else begin
      aux_q <= aux_d;
    end
  end

  // Pointer requests go to the selected pointer through the bank
  always_comb begin
    pif.sel = aux_q[`DDPS_CHOICE_BIT];
    pif.load = 1'b0;
    pif.inc = 1'b0;
    pif.load_val = core_data[PTR_W-1:0];
    case (core_op)
      ddps_pkg::DDPS_OP_LOAD: begin
        pif.load = 1'b1;
      end
      ddps_pkg::DDPS_OP_INC: begin
        pif.inc = 1'b1;
      end
      default: begin
        if (bus_ptr_wr) begin
          pif.load = 1'b1;
          pif.load_val = hwdata[PTR_W-1:0];
        end else if (bus_cmd_wr && hwdata[`DDPS_CMD_INC_BIT]) begin
          pif.inc = 1'b1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Active pointer state
  logic [PTR_W-1:0] ext_addr_q;
  logic [PTR_W-1:0] ext_addr_d;

  // Next active pointer from the next choice and next pointers, so the
  // output comes from a flop yet still changes on the edge of the op
  always_comb begin
    ext_addr_d = aux_d[`DDPS_CHOICE_BIT] ? pif.ptr1_d : pif.ptr0_d;
  end

  // Active pointer register; clears with the pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_addr_q <= PTR_W'(`DDPS_PTR_RST);
    end else begin
      ext_addr_q <= ext_addr_d;
    end
  end

  // Outputs to the core: active pointer and current choice
  assign ext_addr = ext_addr_q;
  assign pointer_choice = aux_q[`DDPS_CHOICE_BIT];

endmodule
`default_nettype wire

// File: verif/ddps_core_model.sv
// Model of the core execution logic that drives the core port.
// Assumes the caller starts each op just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ddps_core_model (
  input wire logic ref_clk,
  output ddps_pkg::ddps_op_e core_op,
  output logic [15:0] core_data
);
  // Idle until the bench asks for an op
  initial begin
    core_op = ddps_pkg::DDPS_OP_NOP;
    core_data = 16'hFFFF;
  end
  // One op per cycle; held until the next edge takes it
  task automatic issue(input ddps_pkg::ddps_op_e op, input logic [15:0] d);
    core_op <= op;
    core_data <= (op == ddps_pkg::DDPS_OP_AUX_WR) ? (d & 16'h0009) : d;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: verif/ddps_top_sva.sv
// Checker for the core port, pointer outputs and bus answer of ddps_top.
// Assumes the bind at the foot and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ddps_top_sva #(
  parameter int PTR_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire ddps_pkg::ddps_op_e core_op,
  input wire logic [15:0] core_data,
  input wire logic [PTR_W-1:0] ext_addr,
  input wire logic pointer_choice
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  load_sets_ptr_a: assert property (core_op == ddps_pkg::DDPS_OP_LOAD |=>
    ext_addr == $past(core_data[PTR_W-1:0])) else $error("load not on ext_addr");
  inc_adds_one_a: assert property (core_op == ddps_pkg::DDPS_OP_INC |=>
    ext_addr == PTR_W'($past(ext_addr) + 1)) else $error("inc wrong");
  aux_inc_flip_a: assert property (core_op == ddps_pkg::DDPS_OP_AUX_INC |=>
    pointer_choice != $past(pointer_choice)) else $error("choice not toggled");
  aux_wr_bit_a: assert property (core_op == ddps_pkg::DDPS_OP_AUX_WR |=>
    pointer_choice == $past(core_data[0])) else $error("choice not bit 0");
  // Two toggles must bring back the untouched pointer
  twin_flip_keep_a: assert property (core_op == ddps_pkg::DDPS_OP_AUX_INC ##1
    core_op == ddps_pkg::DDPS_OP_AUX_INC |=> ext_addr == $past(ext_addr, 2))
    else $error("pointer lost across toggles");
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    !pointer_choice && ext_addr == '0) else $error("reset state wrong");
  resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
  stall_cause_a: assert property (!hreadyout |-> core_op != ddps_pkg::DDPS_OP_NOP)
    else $error("stall without core op");
  idle_no_stall_a: assert property (core_op == ddps_pkg::DDPS_OP_NOP |-> hreadyout)
    else $error("bus stalled while core idle");
endmodule
`default_nettype wire
bind ddps_top ddps_top_sva #(.PTR_W(PTR_W)) ddps_top_sva_i (.ref_clk(ref_clk), .rst(rst),
  .hreadyout(hreadyout), .hresp(hresp), .core_op(core_op), .core_data(core_data),
  .ext_addr(ext_addr), .pointer_choice(pointer_choice));

// File: verif/ddps_tb_top.sv
// Testbench for ddps_top: AHB-Lite master tasks and the core model.
// Assumes the single slave's hreadyout feeds back as hready.
`timescale 1ns/1ps
`default_nettype none
module ddps_tb_top;
  localparam ddps_pkg::ddps_op_e NOP = ddps_pkg::DDPS_OP_NOP;
  localparam ddps_pkg::ddps_op_e LD = ddps_pkg::DDPS_OP_LOAD;
  localparam ddps_pkg::ddps_op_e INC = ddps_pkg::DDPS_OP_INC;
  localparam ddps_pkg::ddps_op_e AI = ddps_pkg::DDPS_OP_AUX_INC;
  localparam ddps_pkg::ddps_op_e AW = ddps_pkg::DDPS_OP_AUX_WR;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [31:0] hrdata_nf, rd_nf;
  logic hreadyout, hresp, pointer_choice;
  logic [15:0] ext_addr, core_data;
  ddps_pkg::ddps_op_e core_op;
  int n_fail = 0;
  int checks = 0;
  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;
  ddps_top ddps_top_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .core_op(core_op), .core_data(core_data), .ext_addr(ext_addr),
    .pointer_choice(pointer_choice));
  ddps_core_model ddps_core_model_i (.ref_clk(ref_clk), .core_op(core_op),
    .core_data(core_data));
  // Same traffic into a build without the user flag; it stalls alike
  ddps_top #(.HAS_USER_FLAG(1'b0)) ddps_top_nf_i (.ref_clk(ref_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata_nf), .hreadyout(),
    .hresp(), .core_op(core_op), .core_data(core_data), .ext_addr(),
    .pointer_choice());
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Bounded wait; a core stall may hold a write, so never open-ended
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 50) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // One single word transfer; read data lands in rd and rd_nf
  task automatic bus(input int wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr[0];
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    rd_nf = hrdata_nf;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(0, 32'h288, 0);
    chk(rd, 32'h0);
    chk(rd_nf, 32'h0);
    chk({31'h0, pointer_choice}, 32'h0);
    bus(0, 32'h300, 0);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask
  // Flag and choice through the bus; reserved bits read 0
  task automatic t_flag();
    bus(1, 32'h288, 32'h9);
    bus(0, 32'h288, 0);
    chk(rd, 32'h9);
    chk(rd_nf, 32'h1);
    chk({31'h0, pointer_choice}, 32'h1);
    bus(1, 32'h288, 32'h0);
    bus(0, 32'h288, 0);
    chk(rd, 32'h0);
    $display("t_flag done");
  endtask
  // Both pointers through the core, wrap on pointer one
  task automatic t_ptrs();
    ddps_core_model_i.issue(AW, 16'h00FF);
    ddps_core_model_i.issue(NOP, 16'h0);
    chk({31'h0, pointer_choice}, 32'h1);
    ddps_core_model_i.issue(AW, 16'h0);
    ddps_core_model_i.issue(LD, 16'h1234);
    ddps_core_model_i.issue(AI, 16'h0);
    ddps_core_model_i.issue(LD, 16'hFFFF);
    ddps_core_model_i.issue(INC, 16'h0);
    ddps_core_model_i.issue(NOP, 16'h0);
    chk({16'h0, ext_addr}, 32'h0);
    bus(0, 32'h294, 0);
    chk(rd, 32'h00001234);
    ddps_core_model_i.issue(AI, 16'h0);
    ddps_core_model_i.issue(AI, 16'h0);
    ddps_core_model_i.issue(AI, 16'h0);
    ddps_core_model_i.issue(NOP, 16'h0);
    chk({16'h0, ext_addr}, 32'h1234);
    chk({31'h0, pointer_choice}, 32'h0);
    $display("t_ptrs done");
  endtask
  // Bus write held off while the core works
  task automatic t_stall();
    fork
      bus(1, 32'h288, 32'h1);
      begin
        repeat (3) ddps_core_model_i.issue(INC, 16'h0);
        ddps_core_model_i.issue(NOP, 16'h0);
      end
    join
    @(posedge ref_clk);
    chk({16'h0, ext_addr}, 32'h0);
    chk({31'h0, pointer_choice}, 32'h1);
    bus(0, 32'h294, 0);
    chk(rd, 32'h00001237);
    $display("t_stall done");
  endtask
  // Active pointer and command words over the bus; selected pointer only
  task automatic t_cmd();
    bus(1, 32'h28C, 32'h0000ABCD);
    bus(0, 32'h28C, 32'h0);
    chk(rd, 32'h0000ABCD);
    bus(0, 32'h294, 32'h0);
    chk(rd, 32'hABCD1237);
    bus(1, 32'h290, 32'h1);
    bus(0, 32'h28C, 32'h0);
    chk(rd, 32'h00001237);
    bus(1, 32'h290, 32'h2);
    bus(0, 32'h28C, 32'h0);
    chk(rd, 32'h00001238);
    bus(1, 32'h290, 32'h3);
    bus(0, 32'h294, 32'h0);
    chk(rd, 32'hABCD1239);
    chk({31'h0, pointer_choice}, 32'h1);
    $display("t_cmd done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_flag();
    t_ptrs();
    t_stall();
    t_cmd();
    print_verdict();
  end
endmodule
`default_nettype wire
